// *** ttl_timetag_log.sv ***
// Time-tag counter, interrupt log pointer and address registers
`timescale 1ns/1ps
module ttl_timetag_log #(
  parameter bit SERIAL_HOST = 1'b1
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  masterResetPin,
  input  wire logic                  softwareResetCmd,
  input  wire logic [2:0]            tickPeriodSelect,
  input  wire logic                  extTickPulse,
  input  wire logic                  tagCounterClearBit,
  input  wire logic                  syncLoadOptionLo,
  input  wire logic                  syncLoadOptionHi,
  input  wire logic                  syncNoDataCommand,
  input  wire logic                  syncWithDataCommand,
  input  wire logic [15:0]           syncDataWord,
  input  wire logic                  irqEvent,
  input  wire logic [15:0]           irqIdentityWord,
  input  wire logic                  irqFromMessage,
  input  wire logic [15:0]           irqDescriptorAddr,
  input  wire logic                  terminalActive,
  input  wire logic [15:0]           messageInfoAddrIn,
  input  wire logic                  hostRead,
  input  wire logic                  hostWrite,
  input  wire logic [3:0]            hostAddr,
  input  wire logic [15:0]           hostWrData,
  output logic      [15:0]           hostRdData,
  output logic                       ramWrite,
  output logic      [15:0]           ramAddr,
  output logic      [15:0]           ramData,
  output logic                       syncLoadDone
);
  import ttl_pkg::*;

  // Whole state in one struct, registered once
  typedef struct packed {
    logic [15:0] timeTag;
    logic [11:0] baseCnt;
    logic [5:0]  tickDiv;
    logic [7:0]  logAddr;
    logic [7:0]  logCount;
    logic        logSecond;
    logic [15:0] pendSource;
    logic [15:0] msgInfoPtr;
    logic        activeSeen;
    logic [7:0]  miwDelay;
    logic        miwTiming;
    logic [15:0] memPtr;
    logic [15:0] rdData;
    logic        ramWr;
    logic [15:0] ramA;
    logic [15:0] ramD;
    logic        syncDone;
  } ttl_state_t;

  ttl_state_t state_reg;
  ttl_state_t state_next;
  logic       tick;
  logic       loadOk;
  logic [5:0] divMax;
  localparam logic [7:0] LOG_ZERO_HI = 8'h00; // Ring sits in the low page

  // Divider length per select code; 2 us base ticks counted above it
  always_comb begin
    unique case (ttl_tick_t'(tickPeriodSelect))
      TP_2US:  divMax = 6'd0;
      TP_4US:  divMax = 6'd1;
      TP_8US:  divMax = 6'd3;
      TP_16US: divMax = 6'd7;
      TP_32US: divMax = 6'd15;
      TP_64US: divMax = 6'd31;
      default: divMax = 6'd0;
    endcase
  end

  // Load qualification from option bits and data word bit 0
  always_comb begin
    unique case ({syncLoadOptionHi, syncLoadOptionLo})
      2'b11:   loadOk = 1'b1;
      2'b01:   loadOk = ~syncDataWord[0];
      2'b10:   loadOk = syncDataWord[0];
      default: loadOk = 1'b0;
    endcase
  end

  // Tick source; undefined code 7 falls back to external clock
  always_comb begin
    if (tickPeriodSelect >= TICK_EXT) begin
      tick = extTickPulse;
    end else begin
      tick = (state_reg.baseCnt == TICK_BASE_M1)
             && (state_reg.tickDiv == divMax);
    end
  end

  // Next-state logic for all registers
  always_comb begin
    state_next = state_reg;
    state_next.ramWr = 1'b0;
    state_next.syncDone = 1'b0;
    // Base 2 us prescaler always runs so tick spacing stays regular
    if (state_reg.baseCnt == TICK_BASE_M1) begin
      state_next.baseCnt = '0;
      state_next.tickDiv = (state_reg.tickDiv >= divMax) ? 6'd0
                           : state_reg.tickDiv + 6'd1;
    end else begin
      state_next.baseCnt = state_reg.baseCnt + 12'd1;
    end
    // Time-tag: clears beat loads, loads beat ticks
    if (tagCounterClearBit || syncNoDataCommand) begin
      state_next.timeTag = WORD_ZERO;
    end else if (syncWithDataCommand && loadOk) begin
      state_next.timeTag = syncDataWord;
    end else if (tick) begin
      state_next.timeTag = state_reg.timeTag + WORD_ONE;
    end
    // Load lands this edge; status logic waits for this strobe
    state_next.syncDone = syncWithDataCommand;
    // Log write: identity word now, source word on the next cycle
    if (state_reg.logSecond) begin
      state_next.ramWr = 1'b1;
      state_next.ramA = {LOG_ZERO_HI, state_reg.logAddr + 8'd1};
      state_next.ramD = state_reg.pendSource;
      state_next.logSecond = 1'b0;
      state_next.logAddr = (state_reg.logAddr == LOG_LAST) ? LOG_BASE
                           : state_reg.logAddr + LOG_STEP;
    end else if (irqEvent) begin
      state_next.ramWr = 1'b1;
      state_next.ramA = {LOG_ZERO_HI, state_reg.logAddr};
      state_next.ramD = irqIdentityWord;
      state_next.pendSource = irqFromMessage ? irqDescriptorAddr
                              : WORD_ZERO;
      state_next.logSecond = 1'b1;
    end
    // Count: read clears, but an event in the same cycle still counts
    if (hostRead && hostAddr == OFS_LOG_PTR) begin
      state_next.logCount = (irqEvent && !state_reg.logSecond) ? 8'd1
                            : 8'd0;
    end
    if (irqEvent && !state_reg.logSecond && !(hostRead
        && hostAddr == OFS_LOG_PTR) && state_reg.logCount != COUNT_MAX) begin
      state_next.logCount = state_reg.logCount + 8'd1;
    end
    // Message info pointer capture 5 us after activity rises
    state_next.activeSeen = terminalActive;
    if (terminalActive && !state_reg.activeSeen) begin
      state_next.miwTiming = 1'b1;
      state_next.miwDelay = MIW_DELAY_CYC - 8'd1;
    end else if (state_reg.miwTiming) begin
      if (state_reg.miwDelay == 8'd1) begin
        state_next.miwTiming = 1'b0;
        state_next.msgInfoPtr = messageInfoAddrIn;
      end
      state_next.miwDelay = state_reg.miwDelay - 8'd1;
    end
    // Host pointer only exists on the serial variant
    if (SERIAL_HOST && hostWrite && hostAddr == OFS_MEM_PTR) begin
      state_next.memPtr = hostWrData;
    end
    // Read mux; unmapped offsets read zero
    unique case (hostAddr)
      OFS_TIME_TAG: state_next.rdData = state_reg.timeTag;
      OFS_LOG_PTR:  state_next.rdData = {state_reg.logCount,
                                         state_reg.logAddr};
      OFS_MSG_INFO: state_next.rdData = state_reg.msgInfoPtr;
      OFS_MEM_PTR:  state_next.rdData = SERIAL_HOST ? state_reg.memPtr
                                        : WORD_ZERO;
      default:      state_next.rdData = WORD_ZERO;
    endcase
    // Soft reset touches only the time-tag; master reset clears all but logAddr, which loads LOG_PTR_RESET
    if (softwareResetCmd) begin
      state_next.timeTag = WORD_ZERO;
    end
    if (masterResetPin) begin
      state_next = '0;
      state_next.logAddr = LOG_PTR_RESET[7:0];
    end
  end

  // Single state register, synchronous active-low reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.logAddr <= LOG_PTR_RESET[7:0];
    end else begin
      state_reg <= state_next;
    end
  end

  assign hostRdData = state_reg.rdData;
  assign ramWrite = state_reg.ramWr;
  assign ramAddr = state_reg.ramA;
  assign ramData = state_reg.ramD;
  assign syncLoadDone = state_reg.syncDone;

  // Log ring pointer and count
  ptr_range_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.logAddr >= LOG_BASE && state_reg.logAddr <= LOG_LAST
    && !state_reg.logAddr[0]) else $error("log pointer out of range");
  ptr_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.logSecond && state_reg.logAddr == LOG_LAST
    && !masterResetPin |=> state_reg.logAddr == LOG_BASE)
    else $error("log pointer did not wrap");
  ptr_step_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.logSecond && state_reg.logAddr != LOG_LAST
    && !masterResetPin
    |=> state_reg.logAddr == $past(state_reg.logAddr) + LOG_STEP)
    else $error("log pointer step wrong");
  count_sat_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.logCount == COUNT_MAX && !masterResetPin
    && !(hostRead && hostAddr == OFS_LOG_PTR) |=> state_reg.logCount
    == COUNT_MAX) else $error("count wrapped");
  count_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    hostRead && hostAddr == OFS_LOG_PTR && !irqEvent |=>
    state_reg.logCount == 8'd0) else $error("count not cleared");
  // Event beside a clearing read is still counted: set wins
  read_set_a: assert property (@(posedge clk) disable iff (!nrst)
    hostRead && hostAddr == OFS_LOG_PTR && irqEvent
    && !state_reg.logSecond && !masterResetPin
    |=> state_reg.logCount == 8'd1) else $error("same-cycle event lost");
  // Two ring words per interrupt
  first_word_a: assert property (@(posedge clk) disable iff (!nrst)
    irqEvent && !state_reg.logSecond && !masterResetPin
    |=> ramWrite && ramAddr == {LOG_ZERO_HI, $past(state_reg.logAddr)}
    && ramData == $past(irqIdentityWord))
    else $error("identity word not written");
  src_word_a: assert property (@(posedge clk) disable iff (!nrst)
    irqEvent && !state_reg.logSecond && !irqFromMessage && !masterResetPin
    |=> ##1 ramWrite && ramData == WORD_ZERO)
    else $error("hardware source not zero");
  // Clears and resets
  sync_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    syncNoDataCommand |=> state_reg.timeTag == WORD_ZERO)
    else $error("sync did not clear tag");
  host_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    tagCounterClearBit |=> state_reg.timeTag == WORD_ZERO)
    else $error("clear bit ignored");
  soft_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    softwareResetCmd && !masterResetPin && !state_reg.logSecond
    |=> state_reg.timeTag == WORD_ZERO
    && state_reg.logAddr == $past(state_reg.logAddr))
    else $error("soft reset effect wrong");
  // Master reset restores every register it owns; soft reset keeps both pointers
  mr_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    masterResetPin |=> {state_reg.logCount, state_reg.logAddr}
    == LOG_PTR_RESET && state_reg.timeTag == WORD_ZERO
    && state_reg.msgInfoPtr == WORD_ZERO && state_reg.memPtr == WORD_ZERO)
    else $error("master reset effect wrong");
  miw_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    softwareResetCmd && !masterResetPin
    && !(state_reg.miwTiming && state_reg.miwDelay == 8'd1)
    |=> $stable(state_reg.msgInfoPtr))
    else $error("soft reset moved message pointer");
  mem_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    softwareResetCmd && !masterResetPin
    && !(hostWrite && hostAddr == OFS_MEM_PTR)
    |=> $stable(state_reg.memPtr))
    else $error("soft reset moved host pointer");
  // Counting
  tick_step_a: assert property (@(posedge clk) disable iff (!nrst)
    tick && !syncWithDataCommand && !syncNoDataCommand
    && !tagCounterClearBit && !softwareResetCmd && !masterResetPin
    |=> state_reg.timeTag == $past(state_reg.timeTag) + WORD_ONE)
    else $error("time-tag step wrong");
  base_range_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.baseCnt <= TICK_BASE_M1) else $error("prescaler overran");
  // Sync option decoding
  load_all_a: assert property (@(posedge clk) disable iff (!nrst)
    syncWithDataCommand && syncLoadOptionHi && syncLoadOptionLo
    && !syncNoDataCommand && !tagCounterClearBit && !softwareResetCmd
    && !masterResetPin |=> state_reg.timeTag == $past(syncDataWord)
    && syncLoadDone) else $error("sync load missing");
  low_load_a: assert property (@(posedge clk) disable iff (!nrst)
    syncWithDataCommand && !syncLoadOptionHi && syncLoadOptionLo
    && !syncDataWord[0] && !syncNoDataCommand && !tagCounterClearBit
    && !softwareResetCmd && !masterResetPin
    |=> state_reg.timeTag == $past(syncDataWord))
    else $error("option 01 load missing");
  high_load_a: assert property (@(posedge clk) disable iff (!nrst)
    syncWithDataCommand && syncLoadOptionHi && !syncLoadOptionLo
    && syncDataWord[0] && !syncNoDataCommand && !tagCounterClearBit
    && !softwareResetCmd && !masterResetPin
    |=> state_reg.timeTag == $past(syncDataWord))
    else $error("option 10 load missing");
  bit_reject_a: assert property (@(posedge clk) disable iff (!nrst)
    syncWithDataCommand && (syncLoadOptionHi ^ syncLoadOptionLo)
    && (syncDataWord[0] == syncLoadOptionLo) && !tick
    && !syncNoDataCommand && !tagCounterClearBit && !softwareResetCmd
    && !masterResetPin |=> $stable(state_reg.timeTag))
    else $error("refused sync word loaded");
  no_load_a: assert property (@(posedge clk) disable iff (!nrst)
    syncWithDataCommand && !syncLoadOptionHi && !syncLoadOptionLo
    && !tick && !tagCounterClearBit && !syncNoDataCommand
    && !softwareResetCmd && !masterResetPin |=> $stable(state_reg.timeTag))
    else $error("unexpected load");
  sync_done_a: assert property (@(posedge clk) disable iff (!nrst)
    syncWithDataCommand && !masterResetPin |=> syncLoadDone)
    else $error("load strobe missing");
  // Address registers
  miw_update_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.miwTiming && state_reg.miwDelay == 8'd1
    && state_reg.activeSeen && !masterResetPin
    |=> state_reg.msgInfoPtr == $past(messageInfoAddrIn))
    else $error("message pointer not captured");
  mem_ptr_a: assert property (@(posedge clk) disable iff (!nrst)
    hostRead && hostAddr == OFS_MEM_PTR && !SERIAL_HOST |=>
    hostRdData == WORD_ZERO) else $error("parallel pointer nonzero");
  par_write_a: assert property (@(posedge clk) disable iff (!nrst)
    !SERIAL_HOST |-> state_reg.memPtr == WORD_ZERO)
    else $error("parallel pointer written");

  // Main scenarios the bench should reach
  read_set_cov: cover property (@(posedge clk) disable iff (!nrst)
    hostRead && hostAddr == OFS_LOG_PTR && irqEvent);
  wrap_cov: cover property (@(posedge clk) disable iff (!nrst)
    state_reg.logSecond && state_reg.logAddr == LOG_LAST);
  sat_cov: cover property (@(posedge clk) disable iff (!nrst)
    state_reg.logCount == COUNT_MAX);
  load_cov: cover property (@(posedge clk) disable iff (!nrst)
    syncWithDataCommand && loadOk);
  miw_cov: cover property (@(posedge clk) disable iff (!nrst)
    state_reg.miwTiming && state_reg.miwDelay == 8'd1);
endmodule

// *** ttl_pkg.sv ***
// Register offsets, reset values and timing constants of the time-tag block
package ttl_pkg;
  localparam logic [3:0]  OFS_TIME_TAG   = 4'h8;
  localparam logic [3:0]  OFS_LOG_PTR    = 4'h9;
  localparam logic [3:0]  OFS_MSG_INFO   = 4'hA;
  localparam logic [3:0]  OFS_MEM_PTR    = 4'hF;
  localparam logic [15:0] LOG_PTR_RESET  = 16'h0040;
  localparam logic [7:0]  LOG_BASE       = 8'h40;
  localparam logic [7:0]  LOG_LAST       = 8'h5E;
  localparam logic [7:0]  LOG_STEP       = 8'h02;
  localparam logic [7:0]  COUNT_MAX      = 8'hFF;
  localparam logic [15:0] WORD_ZERO      = 16'h0000;
  localparam logic [15:0] WORD_ONE       = 16'h0001;
  localparam int          CLK_MHZ        = 20;
  localparam int          TICK_BASE_US   = 2;
  localparam int          TICK_BASE_CYC  = TICK_BASE_US * CLK_MHZ;
  localparam logic [11:0] TICK_BASE_M1   = 12'(TICK_BASE_CYC - 1);
  localparam int          MIW_DELAY_US   = 5;
  localparam logic [7:0]  MIW_DELAY_CYC  = 8'(MIW_DELAY_US * CLK_MHZ);
  localparam logic [2:0]  TICK_EXT       = 3'h6;
  // Tick period select codes: 2,4,8,16,32,64 us then external
  typedef enum logic [2:0] {
    TP_2US  = 3'b000,
    TP_4US  = 3'b001,
    TP_8US  = 3'b010,
    TP_16US = 3'b011,
    TP_32US = 3'b100,
    TP_64US = 3'b101,
    TP_EXT  = 3'b110
  } ttl_tick_t;
endpackage

// *** ttl_ram_model.sv ***
// Shared RAM stand-in that records the words written by the log
`timescale 1ns/1ps
module ttl_ram_model (
  input wire logic        clk,
  input wire logic        ramWrite,
  input wire logic [15:0] ramAddr,
  input wire logic [15:0] ramData
);
  logic [15:0] mem [0:255];
  // Only the low byte reaches the ring, so stray addresses alias
  always @(posedge clk) begin
    if (ramWrite) begin
      mem[ramAddr[7:0]] <= ramData;
    end
  end
endmodule

// *** tb_ttl_timetag_log.sv ***
// Self-checking bench for the time-tag and interrupt log block
`timescale 1ns/1ps
module tb_ttl_timetag_log;
  import ttl_pkg::*;
  logic        clk = 0, nrst = 0, mrp = 0, software_reset_cmd = 0, ext = 0, clr = 0;
  logic [2:0]  sel = TP_EXT;
  logic        opLo = 0, opHi = 0, syncNd = 0, syncWd = 0, irqEv = 0;
  logic        irqMsg = 0, act = 0, rd = 0, wr = 0;
  logic [15:0] syncWord = '0, irqId = '0, irqSrc = '0, miIn = '0;
  logic [15:0] wrData = '0, rdData, rdPar, ramAddr, ramData, par;
  logic [3:0]  addr = '0;
  logic        ramWrite, loadDone;
  logic [31:0] seed = 32'he293_005d;
  int          mismatches = 0;
  int          samples_checked = 0;
  ttl_timetag_log u_ttl_timetag_log (.clk(clk), .nrst(nrst),
    .masterResetPin(mrp), .softwareResetCmd(software_reset_cmd), .tickPeriodSelect(sel),
    .extTickPulse(ext), .tagCounterClearBit(clr), .syncLoadOptionLo(opLo),
    .syncLoadOptionHi(opHi), .syncNoDataCommand(syncNd),
    .syncWithDataCommand(syncWd), .syncDataWord(syncWord), .irqEvent(irqEv),
    .irqIdentityWord(irqId), .irqFromMessage(irqMsg),
    .irqDescriptorAddr(irqSrc), .terminalActive(act),
    .messageInfoAddrIn(miIn), .hostRead(rd), .hostWrite(wr),
    .hostAddr(addr), .hostWrData(wrData), .hostRdData(rdData),
    .ramWrite(ramWrite), .ramAddr(ramAddr), .ramData(ramData),
    .syncLoadDone(loadDone));
  // Parallel variant shares all inputs; only its read data is watched
  ttl_timetag_log #(.SERIAL_HOST(1'b0)) u_ttl_timetag_log_par (.clk(clk),
    .nrst(nrst), .masterResetPin(mrp), .softwareResetCmd(software_reset_cmd),
    .tickPeriodSelect(sel), .extTickPulse(ext), .tagCounterClearBit(clr),
    .syncLoadOptionLo(opLo), .syncLoadOptionHi(opHi),
    .syncNoDataCommand(syncNd), .syncWithDataCommand(syncWd),
    .syncDataWord(syncWord), .irqEvent(irqEv), .irqIdentityWord(irqId),
    .irqFromMessage(irqMsg), .irqDescriptorAddr(irqSrc),
    .terminalActive(act), .messageInfoAddrIn(miIn), .hostRead(rd),
    .hostWrite(wr), .hostAddr(addr), .hostWrData(wrData),
    .hostRdData(rdPar), .ramWrite(), .ramAddr(), .ramData(),
    .syncLoadDone());
  ttl_ram_model u_ttl_ram_model (.clk(clk), .ramWrite(ramWrite),
    .ramAddr(ramAddr), .ramData(ramData));
  // 20 MHz clock
  always #25 clk = ~clk;
  function automatic logic [15:0] syncExp(logic [1:0] op, logic [15:0] d);
    return (op == 2'b11 || (op == 2'b01 && !d[0]) || (op == 2'b10 && d[0]))
      ? d : WORD_ZERO;
  endfunction
  // Fixed-seed LFSR so every run repeats
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read data lands the cycle after the address is taken
  task automatic rdReg(logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdData;
    par = rdPar;
  endtask
  task automatic wrReg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Low cycle after each event keeps the two-cycle spacing
  task automatic irq(logic [15:0] id, logic [15:0] src, logic msg);
    @(posedge clk);
    irqEv <= 1'b1;
    irqId <= id;
    irqSrc <= src;
    irqMsg <= msg;
    @(posedge clk);
    irqEv <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    mismatches++;
    final_report();
  end
  initial begin
    logic [15:0] v, w, m, ids [17], srcs [17];
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdReg(OFS_TIME_TAG, v); check(v, WORD_ZERO);
    rdReg(OFS_LOG_PTR, v); check(v, LOG_PTR_RESET);
    rdReg(OFS_MSG_INFO, v); check(v, WORD_ZERO);
    w = rnd();
    wrReg(OFS_MEM_PTR, w);
    wrReg(OFS_TIME_TAG, ~w);
    rdReg(OFS_MEM_PTR, v); check(v, w);
    check(par, WORD_ZERO);
    rdReg(OFS_TIME_TAG, v); check(v, WORD_ZERO);
    rdReg(4'h3, v); check(v, WORD_ZERO);
    // Every option pair against both values of the low data bit
    for (int o = 0; o < 8; o++) begin
      m = rnd();
      m[0] = o[0];
      @(posedge clk);
      clr <= 1'b1;
      {opHi, opLo} <= o[2:1];
      @(posedge clk);
      clr <= 1'b0;
      syncWd <= 1'b1;
      syncWord <= m;
      @(posedge clk);
      syncWd <= 1'b0;
      #1 if (syncExp(o[2:1], m) != 0) check(loadDone, 1'b1);
      rdReg(OFS_TIME_TAG, v); check(v, syncExp(o[2:1], m));
    end
    // All-ones load then three external ticks wrap through zero
    @(posedge clk);
    syncWd <= 1'b1;
    syncWord <= 16'hFFFF;
    sel <= 3'h7; // Spare code 7 also picks the external tick
    @(posedge clk);
    syncWd <= 1'b0;
    repeat (3) begin
      @(posedge clk);
      ext <= 1'b1;
      @(posedge clk);
      ext <= 1'b0;
    end
    rdReg(OFS_TIME_TAG, v); check(v, 16'h0002);
    @(posedge clk);
    syncNd <= 1'b1;
    @(posedge clk);
    syncNd <= 1'b0;
    rdReg(OFS_TIME_TAG, v); check(v, WORD_ZERO);
    // Divider phase is unknown, so two or three ticks are accepted
    for (int s = 0; s < 6; s++) begin
      @(posedge clk);
      sel <= 3'(s);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat ((100 << s) - 4) @(posedge clk);
      rdReg(OFS_TIME_TAG, v); check(v == 2 || v == 3, 1);
    end
    @(posedge clk);
    sel <= TP_EXT;
    for (int i = 0; i < 17; i++) begin
      ids[i] = rnd();
      srcs[i] = rnd();
      irq(ids[i], srcs[i], i[0]);
    end
    repeat (3) @(posedge clk);
    check(u_ttl_ram_model.mem[8'h40], ids[16]);
    check(u_ttl_ram_model.mem[8'h41], WORD_ZERO);
    check(u_ttl_ram_model.mem[8'h5F], srcs[15]);
    rdReg(OFS_LOG_PTR, v); check(v, 16'h1142);
    rdReg(OFS_LOG_PTR, v); check(v, 16'h0042);
    m = rnd();
    @(posedge clk);
    act <= 1'b1;
    miIn <= m;
    // Capture lands 100 clocks after the rise; read data trails by one
    repeat (98) @(posedge clk);
    rdReg(OFS_MSG_INFO, v); check(v, WORD_ZERO);
    @(posedge clk);
    #1 check(rdData, m);
    @(posedge clk);
    software_reset_cmd <= 1'b1;
    @(posedge clk);
    software_reset_cmd <= 1'b0;
    rdReg(OFS_MSG_INFO, v); check(v, m);
    rdReg(OFS_LOG_PTR, v); check(v, 16'h0042);
    rdReg(OFS_MEM_PTR, v); check(v, w);
    rdReg(OFS_TIME_TAG, v); check(v, WORD_ZERO);
    repeat (260) irq(16'h0001, 16'h0002, 1'b1);
    repeat (3) @(posedge clk);
    rdReg(OFS_LOG_PTR, v); check(v, 16'hFF4A);
    // Clearing read and a new event in one cycle: the event counts
    @(posedge clk);
    addr <= OFS_LOG_PTR;
    rd <= 1'b1;
    irqEv <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    irqEv <= 1'b0;
    rdReg(OFS_LOG_PTR, v); check(v, 16'h014C);
    @(posedge clk);
    mrp <= 1'b1;
    @(posedge clk);
    mrp <= 1'b0;
    rdReg(OFS_LOG_PTR, v); check(v, LOG_PTR_RESET);
    rdReg(OFS_MSG_INFO, v); check(v, WORD_ZERO);
    rdReg(OFS_MEM_PTR, v); check(v, WORD_ZERO);
    final_report();
  end
endmodule
